/* asr_chk.sv */
`timescale 1ns/1ps
module asr_chk (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic conv_start_n,
   input wire logic sclk,
   input wire logic rate_select,
   input wire logic io_lvds,
   input wire logic echo_disable,
   input wire logic lane_a_out,
   input wire logic lane_b_out,
   input wire logic lane_c_out,
   input wire logic lane_d_out,
   input wire logic echo_clock_out
);
   typedef struct packed {
      logic [4:0] shifts;
      logic [3:0] quiet;
      logic [3:0] off;
      logic sclk;
      logic conv;
   } asr_chk_t;

   asr_chk_t st_q;
   asr_chk_t st_d;
   logic [3:0] lanes;

   assign lanes = {lane_d_out, lane_c_out, lane_b_out, lane_a_out};

   // quiet counts cycles with no serial clock or conversion pin movement, off counts cycles of echo disable
   always_comb begin
      st_d = st_q;
      st_d.sclk = sclk;
      st_d.conv = conv_start_n;
      if (sclk != st_q.sclk || conv_start_n != st_q.conv) begin
         st_d.quiet = 4'h0;
      end else if (st_q.quiet != 4'hF) begin
         st_d.quiet = st_q.quiet + 4'h1;
      end
      // shifts counts shift edges since the last conversion fall, up to a full frame
      if (!conv_start_n && st_q.conv) begin
         st_d.shifts = 5'h0;
      end else if (sclk != st_q.sclk && (rate_select || !sclk) && st_q.shifts != 5'h10) begin
         st_d.shifts = st_q.shifts + 5'h1;
      end
      if (!echo_disable) begin
         st_d.off = 4'h0;
      end else if (st_q.off != 4'hF) begin
         st_d.off = st_q.off + 4'h1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   conv_width_a: assert property ($rose(conv_start_n) |-> conv_start_n [*2] ##1 !conv_start_n)
      else $error("conversion pulse width wrong");
   sclk_idle_a: assert property (conv_start_n |-> !sclk)
      else $error("serial clock moved during conversion pulse");
   pad_low_a: assert property ($rose(conv_start_n) && st_q.shifts == 5'h10
      |-> lanes == 4'h0)
      else $error("lanes not low between frames");
   echo_follow_a: assert property (!echo_disable && $rose(sclk) |-> ##[2:6] $rose(echo_clock_out))
      else $error("echo clock did not follow serial clock");
   echo_off_a: assert property (st_q.off >= 4'h8 |-> !echo_clock_out)
      else $error("echo clock active while disabled");
   sdr_shift_a: assert property (!rate_select && $rose(sclk) |-> ##2 $stable(lanes) [*5])
      else $error("lanes moved on rising edge in single rate");
   lane_quiet_a: assert property (st_q.quiet >= 4'h8 |-> $stable(lanes))
      else $error("lanes moved without host activity");
   echo_quiet_a: assert property (st_q.quiet >= 4'h8 |-> $stable(echo_clock_out))
      else $error("echo clock moved without serial clock");
endmodule

/* asr_device.sv */
// Functional notes
// - rise samples, fall starts conversion and readout
// - progress paced only by host serial clock
// - host holds conversion pulse high briefly
// - SDR: falling edge shifts next bit MSB-first
// - host SDR serial clock sized for throughput
// - DDR: both edges shift next bit
// - host DDR serial clock half SDR rate (host here runs both at one half period, SCLK_HALF_CYC)
// - rate select low SDR, high DDR
// - echo clock is aligned delayed serial clock
// - echo clock off when disable pin high
// - SDR data changes on echo fall
// - DDR receiver captures both edges, delays data
// - two pulses, static clock, enter nap
// - serial clock rise wakes from nap
// - two more pulses in nap enter sleep
// - CMOS: serial clock rise wakes sleep
// - host waits after leaving sleep
// - fifth pulse wakes sleep; clock blocks nap
// - pulses alone cycle oper, nap, sleep forever
// - lanes A to D carry channels 1 to 4
// - first result of a burst is stale
// - host waits after power-on before converting
`timescale 1ns/1ps
module asr_device (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire asr_pkg::asr_words_t i_sample,
   output asr_pkg::asr_mode_t o_mode,
   output logic o_readout_active,
   asr_link_if.device link
);
   import asr_pkg::*;

   // pcnt counts conversion pulses seen while the serial clock stays still;
   // smp is the input caught at the last conversion rise, res the word now
   // being converted, sh the per-lane frame with its MSB leaving first
   typedef struct packed {
      asr_mode_t mode;
      logic [2:0] pcnt;
      asr_words_t smp;
      asr_words_t res;
      logic [NUM_LANES-1:0][FRAME_BITS-1:0] sh;
      logic [4:0] bcnt;
      logic active;
      logic conv_p;
      logic sclk_p;
      logic echo;
      logic [NUM_LANES-1:0] lane;
   } asr_dev_st_t;

   asr_dev_st_t dev_q;
   asr_dev_st_t dev_d;
   logic [LINK_PINS-1:0] pin_raw;
   logic [LINK_PINS-1:0] pin_lvl;
   logic conv_rise;
   logic conv_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic sclk_any;
   logic shift_edge;
   logic [2:0] pcnt_base;
   logic [2:0] pcnt_next;
   logic ddr_mode;
   logic lvds_mode;
   logic echo_off;

   assign pin_raw[PIN_CONV] = link.conv_start_n;
   assign pin_raw[PIN_SCLK] = link.sclk;
   assign pin_raw[PIN_RATE] = link.rate_select;
   assign pin_raw[PIN_LVDS] = link.io_lvds;
   assign pin_raw[PIN_ECHO_OFF] = link.echo_disable;

   asr_sync3 #(
      .WIDTH(LINK_PINS)
   ) u_pin_sync (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_async(pin_raw),
      .o_level(pin_lvl)
   );

   // edges are found on the synchronised levels, in the same cycle they settle
   always_comb begin
      ddr_mode = pin_lvl[PIN_RATE];
      lvds_mode = pin_lvl[PIN_LVDS];
      echo_off = pin_lvl[PIN_ECHO_OFF];
      conv_rise = pin_lvl[PIN_CONV] && !dev_q.conv_p;
      conv_fall = !pin_lvl[PIN_CONV] && dev_q.conv_p;
      sclk_rise = pin_lvl[PIN_SCLK] && !dev_q.sclk_p;
      sclk_fall = !pin_lvl[PIN_SCLK] && dev_q.sclk_p;
      sclk_any = sclk_rise || sclk_fall;
      if (ddr_mode) begin
         shift_edge = sclk_any;
      end else begin
         shift_edge = sclk_fall;
      end
      // any serial clock activity restarts the pulse count
      // a conversion rise that meets a clock edge counts from zero
      pcnt_base = sclk_any ? 3'h0 : dev_q.pcnt;
      pcnt_next = pcnt_base + 3'h1;
   end

   always_comb begin
      dev_d = dev_q;
      dev_d.conv_p = pin_lvl[PIN_CONV];
      dev_d.sclk_p = pin_lvl[PIN_SCLK];
      dev_d.pcnt = pcnt_base;

      // wake from a serial clock rise outside a readout frame only
      if (sclk_rise && !dev_q.active) begin
         case (dev_q.mode)
            MODE_NAP: begin
               dev_d.mode = MODE_OPER;
            end
            MODE_SLEEP: begin
               if (!lvds_mode) begin
                  dev_d.mode = MODE_OPER;
               end
            end
            default: begin
               dev_d.mode = dev_q.mode;
            end
         endcase
      end

      if (conv_rise) begin
         dev_d.smp = i_sample;
         dev_d.pcnt = pcnt_next;
         case (pcnt_next)
            NAP_PULSES: begin
               dev_d.mode = MODE_NAP;
            end
            SLEEP_PULSES: begin
               dev_d.mode = MODE_SLEEP;
            end
            WAKE_PULSES: begin
               dev_d.mode = MODE_OPER;
               dev_d.pcnt = 3'h0;
            end
            default: begin
               dev_d.mode = dev_d.mode;
            end
         endcase
      end

      if (conv_fall && dev_q.mode == MODE_OPER) begin
         // a fall during a frame still in flight restarts the frame
         // the word sent now is the one converted on the previous pulse
         for (int i = 0; i < NUM_LANES; i++) begin
            dev_d.sh[i] = {dev_q.res[i], 1'b0};
         end
         dev_d.res = dev_q.smp;
         dev_d.active = 1'b1;
         dev_d.bcnt = 5'h0;
      end else if (dev_q.active && shift_edge) begin
         // shifting happens only on host clock edges
         for (int i = 0; i < NUM_LANES; i++) begin
            dev_d.sh[i] = {dev_q.sh[i][FRAME_BITS-2:0], 1'b0};
         end
         dev_d.bcnt = dev_q.bcnt + 5'h1;
         // the sixteenth shift ends the frame and the lanes fall back low
         if (dev_q.bcnt == LAST_BIT) begin
            dev_d.active = 1'b0;
         end
      end

      // a frame left unclocked is dropped once the part powers down, so the
      // next serial clock rise is free to act as a wake event
      if (dev_d.mode != MODE_OPER) begin
         dev_d.active = 1'b0;
         dev_d.bcnt = 5'h0;
      end

      // lane i always carries channel i, in either I/O standard
      // LVDS only blocks the serial clock wake from sleep; it does not change which word a lane carries
      for (int i = 0; i < NUM_LANES; i++) begin
         dev_d.lane[i] = dev_d.active ? dev_d.sh[i][FRAME_BITS-1] : 1'b0;
      end
      // echo registered in the same cycle as the lanes keeps them aligned
      // with the echo off the receiver sees no edge at all
      if (echo_off) begin
         dev_d.echo = 1'b0;
      end else begin
         dev_d.echo = pin_lvl[PIN_SCLK];
      end

      // power-on state: operating, no frame, lanes and echo low
      if (!i_resetn) begin
         dev_d = '0;
         dev_d.mode = MODE_OPER;
      end
   end

   always_ff @(posedge i_clock) begin
      dev_q <= dev_d;
   end

   assign o_mode = dev_q.mode;
   assign o_readout_active = dev_q.active;
   assign link.lane_a_out = dev_q.lane[0];
   assign link.lane_b_out = dev_q.lane[1];
   assign link.lane_c_out = dev_q.lane[2];
   assign link.lane_d_out = dev_q.lane[3];
   assign link.echo_clock_out = dev_q.echo;
endmodule

/* asr_host.sv */
`timescale 1ns/1ps
module asr_host #(
   parameter int POR_WAIT = asr_pkg::POR_WAIT_CYC,
   parameter int SLEEP_WAIT = asr_pkg::SLEEP_WAIT_CYC
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_cmd_valid,
   input wire asr_pkg::asr_cmd_t i_cmd,
   input wire logic i_rate_select,
   input wire logic i_io_lvds,
   input wire logic i_echo_off,
   output logic o_busy,
   output logic o_valid,
   output logic o_first_invalid,
   output asr_pkg::asr_words_t o_ch_data,
   asr_link_if.host link
);
   import asr_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SETTLE = 6'h02,
      ST_CNV_HI = 6'h04,
      ST_CNV_GAP = 6'h08,
      ST_CLOCKING = 6'h10,
      ST_TAIL = 6'h20
   } asr_hst_t;

   typedef struct packed {
      asr_hst_t st;
      logic [TMR_BITS-1:0] tmr;
      logic [5:0] tcnt;
      asr_cmd_t cmd;
      logic [2:0] pcnt;
      logic first;
      logic conv_n;
      logic sclk;
      logic [2:0] cfg;
      logic [NUM_LANES-1:0] dly;
      logic echo_p;
      logic [NUM_LANES-1:0][FRAME_BITS-1:0] cap;
      asr_words_t data;
      logic valid;
      logic first_out;
      logic busy;
   } asr_host_st_t;

   asr_host_st_t h_q;
   asr_host_st_t h_d;
   logic [LINK_PINS-1:0] ret_raw;
   logic [LINK_PINS-1:0] ret_lvl;
   logic e_rise;
   logic e_fall;
   logic [NUM_LANES-1:0] bit_in;

   assign ret_raw = {link.echo_clock_out, link.lane_d_out, link.lane_c_out,
                     link.lane_b_out, link.lane_a_out};

   asr_sync3 #(
      .WIDTH(LINK_PINS)
   ) u_ret_sync (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_async(ret_raw),
      .o_level(ret_lvl)
   );

   always_comb begin
      h_d = h_q;
      h_d.valid = 1'b0;
      h_d.cfg = {i_echo_off, i_io_lvds, i_rate_select};
      h_d.echo_p = ret_lvl[RET_ECHO];
      h_d.dly = ret_lvl[NUM_LANES-1:0];
      e_rise = ret_lvl[RET_ECHO] && !h_q.echo_p;
      e_fall = !ret_lvl[RET_ECHO] && h_q.echo_p;
      // DDR takes the bit held before each edge; SDR samples on the rise
      bit_in = h_q.cfg[0] ? h_q.dly : ret_lvl[NUM_LANES-1:0];
      if (e_rise || (h_q.cfg[0] && e_fall)) begin
         for (int i = 0; i < NUM_LANES; i++) begin
            h_d.cap[i] = {h_q.cap[i][FRAME_BITS-2:0], bit_in[i]};
         end
      end
      if (h_q.tmr != '0) begin
         h_d.tmr = h_q.tmr - 1'b1;
      end

      case (h_q.st)
         ST_IDLE: begin
            if (i_cmd_valid) begin
               h_d.cmd = i_cmd;
               h_d.tmr = TMR_BITS'(CNV_HIGH_CYC - 1);
               if (i_cmd == CMD_WAKE) begin
                  h_d.sclk = 1'b1;
                  h_d.tmr = TMR_BITS'(SCLK_HALF_CYC - 1);
                  h_d.st = ST_CNV_GAP;
               end else begin
                  h_d.conv_n = 1'b1;
                  h_d.st = ST_CNV_HI;
               end
            end
         end
         ST_SETTLE: begin
            if (h_q.tmr == '0) begin
               h_d.st = ST_IDLE;
            end
         end
         ST_CNV_HI: begin
            if (h_q.tmr == '0) begin
               h_d.conv_n = 1'b0;
               h_d.tmr = TMR_BITS'(CONV_GAP_CYC - 1);
               h_d.st = ST_CNV_GAP;
            end
         end
         ST_CNV_GAP: begin
            if (h_q.tmr == '0) begin
               h_d.sclk = 1'b0;
               h_d.st = ST_IDLE;
               if (h_q.cmd == CMD_READ) begin
                  h_d.pcnt = 3'h0;
                  h_d.tcnt = 6'h0;
                  h_d.tmr = TMR_BITS'(SCLK_HALF_CYC - 1);
                  h_d.st = ST_CLOCKING;
               end else if (h_q.cmd == CMD_WAKE) begin
                  h_d.first = 1'b1;
                  h_d.pcnt = 3'h0;
                  if (h_q.pcnt >= SLEEP_PULSES) begin
                     h_d.tmr = TMR_BITS'(SLEEP_WAIT);
                     h_d.st = ST_SETTLE;
                  end
               end else begin
                  h_d.first = 1'b1;
                  h_d.pcnt = h_q.pcnt + 3'h1;
                  if (h_q.pcnt + 3'h1 == WAKE_PULSES) begin
                     h_d.pcnt = 3'h0;
                     h_d.tmr = TMR_BITS'(SLEEP_WAIT);
                     h_d.st = ST_SETTLE;
                  end
               end
            end
         end
         ST_CLOCKING: begin
            if (h_q.tmr == '0) begin
               h_d.sclk = !h_q.sclk;
               h_d.tcnt = h_q.tcnt + 6'h1;
               h_d.tmr = TMR_BITS'(SCLK_HALF_CYC - 1);
               if (h_q.tcnt + 6'h1 == (h_q.cfg[0] ? DDR_TOGGLES : SDR_TOGGLES)) begin
                  h_d.tmr = TMR_BITS'(TAIL_CYC - 1);
                  h_d.st = ST_TAIL;
               end
            end
         end
         ST_TAIL: begin
            if (h_q.tmr == '0) begin
               for (int i = 0; i < NUM_LANES; i++) begin
                  h_d.data[i] = h_q.cap[i][FRAME_BITS-1:1];
               end
               h_d.valid = 1'b1;
               h_d.first_out = h_q.first;
               h_d.first = 1'b0;
               h_d.st = ST_IDLE;
            end
         end
         default: begin
            h_d.st = ST_IDLE;
         end
      endcase
      h_d.busy = (h_d.st != ST_IDLE);

      if (!i_resetn) begin
         h_d = '0;
         h_d.st = ST_SETTLE;
         h_d.tmr = TMR_BITS'(POR_WAIT);
         h_d.first = 1'b1;
         h_d.busy = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      h_q <= h_d;
   end

   assign o_busy = h_q.busy;
   assign o_valid = h_q.valid;
   assign o_first_invalid = h_q.first_out;
   assign o_ch_data = h_q.data;
   assign link.conv_start_n = h_q.conv_n;
   assign link.sclk = h_q.sclk;
   assign link.rate_select = h_q.cfg[0];
   assign link.io_lvds = h_q.cfg[1];
   assign link.echo_disable = h_q.cfg[2];
endmodule

/* asr_link_if.sv */
`timescale 1ns/1ps
interface asr_link_if;
   logic conv_start_n;
   logic sclk;
   logic rate_select;
   logic io_lvds;
   logic echo_disable;
   logic lane_a_out;
   logic lane_b_out;
   logic lane_c_out;
   logic lane_d_out;
   logic echo_clock_out;

   modport device (
      input conv_start_n, sclk, rate_select, io_lvds, echo_disable,
      output lane_a_out, lane_b_out, lane_c_out, lane_d_out, echo_clock_out
   );
   modport host (
      output conv_start_n, sclk, rate_select, io_lvds, echo_disable,
      input lane_a_out, lane_b_out, lane_c_out, lane_d_out, echo_clock_out
   );
endinterface

/* asr_pkg.sv */
package asr_pkg;
   localparam int NUM_LANES = 4;
   localparam int WORD_BITS = 15;
   localparam int FRAME_BITS = 16;
   localparam int LINK_PINS = 5;

   // pin positions inside the device's synchronised input bundle
   localparam int PIN_CONV = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_RATE = 2;
   localparam int PIN_LVDS = 3;
   localparam int PIN_ECHO_OFF = 4;
   // positions inside the host's synchronised return bundle
   localparam int RET_ECHO = 4;

   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_PERIOD_NS = 800;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int CNV_HIGH_NS = 30;
   localparam int CNV_HIGH_RAW = (CNV_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // a pin level needs two cycles to pass the synchroniser's agreement check
   localparam int LINK_MIN_CYC = 2;
   localparam int CNV_HIGH_CYC = (CNV_HIGH_RAW < LINK_MIN_CYC) ? LINK_MIN_CYC : CNV_HIGH_RAW;
   localparam int CONV_GAP_CYC = 4;
   // covers the round trip through both synchronisers after the last clock edge
   localparam int TAIL_CYC = 12;
   localparam int POR_WAIT_MS = 10;
   localparam int SLEEP_WAIT_MS = 10;
   localparam int POR_WAIT_CYC = POR_WAIT_MS * (1000000 / CLK_PERIOD_NS);
   localparam int SLEEP_WAIT_CYC = SLEEP_WAIT_MS * (1000000 / CLK_PERIOD_NS);
   localparam int TMR_BITS = 17;

   localparam logic [5:0] SDR_TOGGLES = 6'h20;
   localparam logic [5:0] DDR_TOGGLES = 6'h10;
   localparam logic [4:0] LAST_BIT = 5'h0F;
   localparam logic [2:0] NAP_PULSES = 3'h2;
   localparam logic [2:0] SLEEP_PULSES = 3'h4;
   localparam logic [2:0] WAKE_PULSES = 3'h5;

   typedef logic [NUM_LANES-1:0][WORD_BITS-1:0] asr_words_t;

   typedef enum logic [2:0] {
      MODE_OPER = 3'h1,
      MODE_NAP = 3'h2,
      MODE_SLEEP = 3'h4
   } asr_mode_t;

   typedef enum logic [1:0] {
      CMD_READ = 2'h0,
      CMD_PULSE = 2'h1,
      CMD_WAKE = 2'h2
   } asr_cmd_t;
endpackage

/* asr_sync3.sv */
`timescale 1ns/1ps
module asr_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);
   import asr_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } asr_sync_st_t;

   asr_sync_st_t sync_q;
   asr_sync_st_t sync_d;

   always_comb begin
      sync_d = sync_q;
      sync_d.s1 = i_async;
      sync_d.s2 = sync_q.s1;
      sync_d.s3 = sync_q.s2;
      // a bit takes its new level only once stages two and three agree
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_q.s2[i] == sync_q.s3[i]) begin
            sync_d.lvl[i] = sync_q.s3[i];
         end
      end
      if (!i_resetn) begin
         sync_d = '0;
      end
   end

   always_ff @(posedge i_clock) begin
      sync_q <= sync_d;
   end

   assign o_level = sync_q.lvl;
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import asr_pkg::*;
   localparam asr_words_t P1 = {15'h0001, 15'h4000, 15'h0000, 15'h7FFF};
   localparam asr_words_t P2 = {15'h7FFF, 15'h0000, 15'h2AAA, 15'h5555};
   localparam asr_words_t P3 = {15'h4000, 15'h3FFF, 15'h0001, 15'h0000};
   localparam asr_words_t P4 = {15'h1234, 15'h0F0F, 15'h7000, 15'h0002};
   localparam asr_words_t P5 = {15'h6001, 15'h1000, 15'h7FFE, 15'h4001};

   logic i_clock = 1'b0;
   logic i_resetn = 1'b0;
   logic cmd_valid = 1'b0;
   asr_cmd_t cmd = CMD_READ;
   logic rate_sel = 1'b0;
   logic io_lvds = 1'b0;
   logic echo_off = 1'b0;
   asr_words_t sample = 60'h0;
   asr_words_t last_exp = 60'h0;
   asr_mode_t mode;
   logic readout;
   logic busy;
   logic valid;
   logic first_inv;
   asr_words_t ch_data;
   int fails = 0;
   int comparisons = 0;

   always #50 i_clock = ~i_clock;

   asr_link_if link_if();

   asr_device asr_device_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_sample(sample),
      .o_mode(mode), .o_readout_active(readout), .link(link_if.device));

   asr_host #(.POR_WAIT(20), .SLEEP_WAIT(20)) asr_host_inst (.i_clock(i_clock),
      .i_resetn(i_resetn), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_rate_select(rate_sel),
      .i_io_lvds(io_lvds), .i_echo_off(echo_off), .o_busy(busy), .o_valid(valid),
      .o_first_invalid(first_inv), .o_ch_data(ch_data), .link(link_if.host));

   asr_chk asr_chk_inst (.i_clock(i_clock), .i_resetn(i_resetn),
      .conv_start_n(link_if.conv_start_n), .sclk(link_if.sclk),
      .rate_select(link_if.rate_select), .io_lvds(link_if.io_lvds),
      .echo_disable(link_if.echo_disable), .lane_a_out(link_if.lane_a_out),
      .lane_b_out(link_if.lane_b_out), .lane_c_out(link_if.lane_c_out),
      .lane_d_out(link_if.lane_d_out), .echo_clock_out(link_if.echo_clock_out));

   task automatic chk(input logic [59:0] seen, input logic [59:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic settle;
      repeat (8) begin
         @(posedge i_clock);
         #1;
      end
   endtask

   task automatic wait_idle;
      int n;
      for (n = 0; n < 400 && busy !== 1'b0; n++) begin
         @(posedge i_clock);
         #1;
      end
      chk(60'(busy), 60'h0);
   endtask

   task automatic go(input asr_cmd_t c);
      wait_idle();
      cmd_valid = 1'b1;
      cmd = c;
      @(posedge i_clock);
      #1;
      cmd_valid = 1'b0;
   endtask

   task automatic pulses(input int n);
      repeat (n) go(CMD_PULSE);
   endtask

   task automatic mode_is(input asr_mode_t m);
      wait_idle();
      settle();
      chk(60'(mode), 60'(m));
   endtask

   // result comes one conversion late: expect what the previous conversion captured
   task automatic rd(input asr_words_t nxt, input logic exp_first);
      asr_words_t exp;
      int n;
      // with the echo off the receiver takes no bits and keeps its last word
      exp = echo_off ? last_exp : sample;
      last_exp = exp;
      sample = nxt;
      go(CMD_READ);
      // commands while busy must be ignored
      repeat (2) begin
         @(posedge i_clock);
         #1;
         cmd_valid = 1'b1;
         cmd = CMD_PULSE;
         @(posedge i_clock);
         #1;
         cmd_valid = 1'b0;
      end
      for (n = 0; n < 400 && valid !== 1'b1; n++) begin
         @(posedge i_clock);
         #1;
      end
      chk(60'(valid), 60'h1);
      chk(60'(readout), 60'h0);
      chk(60'(first_inv), 60'(exp_first));
      if (!exp_first) begin
         chk(ch_data, exp);
      end
   endtask

   initial begin
      repeat (4) @(posedge i_clock);
      #1;
      i_resetn = 1'b1;
      rd(P1, 1'b1);
      rd(P2, 1'b0);
      rd(P3, 1'b0);
      mode_is(MODE_OPER);
      rate_sel = 1'b1;
      settle();
      rd(P4, 1'b0);
      rd(P5, 1'b0);
      io_lvds = 1'b1;
      settle();
      rd(P1, 1'b0);
      pulses(2);
      mode_is(MODE_NAP);
      pulses(2);
      mode_is(MODE_SLEEP);
      pulses(1);
      mode_is(MODE_OPER);
      chk(60'(readout), 60'h1);
      pulses(2);
      mode_is(MODE_NAP);
      chk(60'(readout), 60'h0);
      go(CMD_WAKE);
      mode_is(MODE_OPER);
      io_lvds = 1'b0;
      settle();
      pulses(4);
      mode_is(MODE_SLEEP);
      go(CMD_WAKE);
      mode_is(MODE_OPER);
      rd(P2, 1'b1);
      rd(P3, 1'b0);
      echo_off = 1'b1;
      settle();
      rd(P4, 1'b0);
      echo_off = 1'b0;
      settle();
      rd(P5, 1'b0);
      close_out();
   end

   initial begin
      #3000000;
      fails++;
      close_out();
   end
endmodule
